/* File: cpu_operand_register_file_bench.sv */
`timescale 1ns/10ps
`include "opreg_map.svh"
module cpu_operand_register_file_bench;
  logic CLK_SYS, RST_B, SIZE_EXPLICIT, FIELD_IS_ADDR, IMPLIED_IS_ADDR;
  logic RD_EN, WR_EN, EA_ADJUST, MISALIGNED, SIZE_ERR, store;
  logic [1:0] SIZE_CODE, SIZE_IMPLIED, LOCATE;
  logic [2:0] FIELD_REG, IMPLIED_REG;
  logic [5:0] EA_FIELD;
  logic [31:0] WR_DATA, RD_DATA;
  logic [23:0] MEM_ADDR_HI, MEM_ADDR_LO;
  int failures;
  int comparisons;
  opreg_file opreg_file_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .SIZE_EXPLICIT(SIZE_EXPLICIT), .SIZE_CODE(SIZE_CODE),
    .SIZE_IMPLIED(SIZE_IMPLIED), .LOCATE(LOCATE), .FIELD_REG(FIELD_REG),
    .FIELD_IS_ADDR(FIELD_IS_ADDR), .EA_FIELD(EA_FIELD),
    .IMPLIED_REG(IMPLIED_REG), .IMPLIED_IS_ADDR(IMPLIED_IS_ADDR),
    .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
    .EA_ADJUST(EA_ADJUST), .RD_DATA(RD_DATA), .MEM_ADDR_HI(MEM_ADDR_HI),
    .MEM_ADDR_LO(MEM_ADDR_LO), .MISALIGNED(MISALIGNED),
    .SIZE_ERR(SIZE_ERR));
  opreg_mem_model opreg_mem_model_i (.CLK_SYS(CLK_SYS), .STORE(store),
    .ADDR_HI(MEM_ADDR_HI), .ADDR_LO(MEM_ADDR_LO), .DATA(WR_DATA));
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Called at a falling edge; results of the next rising edge are settled
  task automatic op(input logic [1:0] loc, input logic [2:0] r,
    input logic a, input logic [5:0] ea, input logic [1:0] sz,
    input logic rd, wr, adj, input logic [31:0] d);
    // The unused source gets another register so a wrong pick shows
    LOCATE = loc;
    FIELD_REG = (loc == 2'h2) ? ~r : r;
    FIELD_IS_ADDR = (loc == 2'h2) ? ~a : a;
    IMPLIED_REG = (loc == 2'h2) ? r : ~r;
    IMPLIED_IS_ADDR = (loc == 2'h2) ? a : ~a;
    EA_FIELD = ea;
    SIZE_CODE = SIZE_EXPLICIT ? sz : `SZ_LONG;
    SIZE_IMPLIED = SIZE_EXPLICIT ? `SZ_LONG : sz;
    RD_EN = rd;
    WR_EN = wr;
    EA_ADJUST = adj;
    WR_DATA = d;
    // Strobes stay up; the next call or an idle step lowers them
    @(negedge CLK_SYS);
  endtask
  task automatic t_data();
    op(2'h0, 3'h0, 1'b0, 6'h00, `SZ_LONG, 0, 1, 0, 32'h1234_5678);
    op(2'h0, 3'h0, 1'b0, 6'h00, `SZ_BYTE, 0, 1, 0, 32'hFFFF_FFAB);
    op(2'h0, 3'h0, 1'b0, 6'h00, `SZ_LONG, 1, 0, 0, 32'h0);
    chk("d0 long", 32'h1234_56AB, RD_DATA);
    op(2'h1, 3'h0, 1'b0, 6'h00, `SZ_WORD, 1, 0, 0, 32'h0);
    chk("d0 word", 32'h0000_56AB, RD_DATA);
    op(2'h0, 3'h5, 1'b0, 6'h00, `SZ_LONG, 0, 1, 0, 32'h1357_2468);
    op(2'h0, 3'h5, 1'b0, 6'h00, `SZ_WORD, 0, 1, 0, 32'hAAAA_9876);
    op(2'h0, 3'h5, 1'b0, 6'h00, `SZ_BYTE, 1, 0, 0, 32'h0);
    chk("d5 byte", 32'h0000_0076, RD_DATA);
    op(2'h0, 3'h5, 1'b0, 6'h00, `SZ_LONG, 1, 0, 0, 32'h0);
    chk("d5 long", 32'h1357_9876, RD_DATA);
  endtask
  task automatic t_addr();
    op(2'h0, 3'h1, 1'b1, 6'h00, `SZ_WORD, 0, 1, 0, 32'h0000_8000);
    op(2'h0, 3'h1, 1'b1, 6'h00, `SZ_LONG, 1, 0, 0, 32'h0);
    chk("a1 long", 32'hFFFF_8000, RD_DATA);
    op(2'h0, 3'h1, 1'b1, 6'h00, `SZ_BYTE, 0, 1, 0, 32'h0);
    chk("size err", 32'h1, {31'h0, SIZE_ERR});
    op(2'h1, 3'h0, 1'b0, 6'h09, `SZ_WORD, 1, 0, 0, 32'h0);
    chk("a1 word", 32'h0000_8000, RD_DATA);
  endtask
  task automatic t_step();
    op(2'h0, 3'h7, 1'b1, 6'h00, `SZ_LONG, 0, 1, 0, 32'h100);
    op(2'h0, 3'h2, 1'b1, 6'h00, `SZ_LONG, 0, 1, 0, 32'h200);
    op(2'h0, 3'h3, 1'b1, 6'h00, `SZ_LONG, 0, 1, 0, 32'h008);
    op(2'h1, 3'h0, 1'b0, 6'h1F, `SZ_BYTE, 0, 0, 1, 32'h0);
    op(2'h1, 3'h0, 1'b0, 6'h1F, `SZ_BYTE, 0, 0, 1, 32'h0);
    chk("sp step", 32'h102, {8'h0, MEM_ADDR_HI});
    op(2'h1, 3'h0, 1'b0, 6'h22, `SZ_BYTE, 0, 0, 1, 32'h0);
    chk("predec", 32'h1FF, {8'h0, MEM_ADDR_HI});
    op(2'h1, 3'h0, 1'b0, 6'h1B, `SZ_LONG, 0, 0, 1, 32'h1122_3344);
    chk("long lo", 32'h00A, {8'h0, MEM_ADDR_LO});
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    EA_ADJUST = 1'b0;
    store = 1'b1;
    @(negedge CLK_SYS);
    store = 1'b0;
    chk("byte 8", 32'h11, {24'h0, opreg_mem_model_i.mem[8]});
    chk("byte B", 32'h44, {24'h0, opreg_mem_model_i.mem[11]});
    op(2'h1, 3'h0, 1'b0, 6'h1B, `SZ_LONG, 0, 0, 1, 32'h0);
    chk("postinc", 32'h00C, {8'h0, MEM_ADDR_HI});
  endtask
  task automatic t_misc();
    op(2'h0, 3'h4, 1'b1, 6'h00, `SZ_LONG, 0, 1, 0, 32'h005);
    op(2'h1, 3'h0, 1'b0, 6'h24, `SZ_WORD, 0, 0, 1, 32'h0);
    chk("misaligned", 32'h1, {31'h0, MISALIGNED});
    SIZE_EXPLICIT = 1'b0;
    op(2'h2, 3'h0, 1'b0, 6'h00, `SZ_WORD, 1, 0, 0, 32'h0);
    chk("implied", 32'h0000_56AB, RD_DATA);
    SIZE_EXPLICIT = 1'b1;
  endtask
  initial begin
    failures = 0;
    comparisons = 0;
    RST_B = 1'b0;
    SIZE_EXPLICIT = 1'b1;
    store = 1'b0;
    op(2'h0, 3'h0, 1'b0, 6'h00, `SZ_BYTE, 0, 0, 0, 32'h0);
    repeat (20) @(negedge CLK_SYS);
    RST_B = 1'b1;
    @(negedge CLK_SYS);
    t_data();
    t_addr();
    t_step();
    t_misc();
    summarize();
  end
endmodule

/* File: opreg_ea_decode.sv */
`timescale 1ns/10ps
`include "opreg_map.svh"
module opreg_ea_decode (
  opreg_ea_if.decoder eab
);
  always_comb begin
    eab.mode = eab.ea[`EA_MODE_HI:`EA_MODE_LO];
    eab.regnum = eab.ea[`EA_REG_HI:`EA_REG_LO];
  end
endmodule

/* File: opreg_ea_if.sv */
`timescale 1ns/10ps
interface opreg_ea_if;
  logic [5:0] ea;
  logic [2:0] mode;
  logic [2:0] regnum;
  modport decoder (input ea, output mode, output regnum);
  modport user (output ea, input mode, input regnum);
endinterface

/* File: opreg_file.sv */
`timescale 1ns/10ps
`include "opreg_map.svh"
module opreg_file #(
  parameter int NUM_DREG = 8,
  parameter int NUM_AREG = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic SIZE_EXPLICIT,
  input wire logic [1:0] SIZE_CODE,
  input wire logic [1:0] SIZE_IMPLIED,
  input wire logic [1:0] LOCATE,
  input wire logic [2:0] FIELD_REG,
  input wire logic FIELD_IS_ADDR,
  input wire logic [5:0] EA_FIELD,
  input wire logic [2:0] IMPLIED_REG,
  input wire logic IMPLIED_IS_ADDR,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic [31:0] WR_DATA,
  input wire logic EA_ADJUST,
  output logic [31:0] RD_DATA,
  output logic [23:0] MEM_ADDR_HI,
  output logic [23:0] MEM_ADDR_LO,
  output logic MISALIGNED,
  output logic SIZE_ERR
);
  // Register numbers are three bits wide, so each bank is exactly eight
  if (NUM_DREG != 8 || NUM_AREG != 8) begin : g_bank_check
    $error("opreg_file serves eight data and eight address registers");
  end

  logic [31:0] dreg [NUM_DREG];
  logic [31:0] areg [NUM_AREG];
  logic [31:0] next_dreg [NUM_DREG];
  logic [31:0] next_areg [NUM_AREG];
  logic [31:0] next_rd_data;
  logic [23:0] next_addr_hi;
  logic [23:0] next_addr_lo;
  logic next_misaligned;
  logic next_size_err;
  opreg_pkg::size_t size;
  logic [2:0] sel;
  logic is_addr;
  logic [31:0] step;
  logic [31:0] cur;
  logic [31:0] ptr;
  opreg_ea_if eab();

  assign eab.ea = EA_FIELD;
  opreg_ea_decode u_dec (
    .eab(eab)
  );

  always_comb begin
    size = SIZE_EXPLICIT ? SIZE_CODE : SIZE_IMPLIED;
  end

  always_comb begin
    sel = FIELD_REG;
    is_addr = FIELD_IS_ADDR;
    case (opreg_pkg::locate_e'(LOCATE))
      opreg_pkg::SRC_FIELD: begin
        sel = FIELD_REG;
        is_addr = FIELD_IS_ADDR;
      end
      opreg_pkg::SRC_EA: begin
        sel = eab.regnum;
        is_addr = (eab.mode != `MODE_DREG);
      end
      opreg_pkg::SRC_IMPLIED: begin
        sel = IMPLIED_REG;
        is_addr = IMPLIED_IS_ADDR;
      end
      default: begin
        sel = FIELD_REG;
        is_addr = FIELD_IS_ADDR;
      end
    endcase
  end

  // step by size, stack pointer bytes by two
  always_comb begin
    case (size)
      `SZ_BYTE: step = (sel == `SP_INDEX) ? `STEP_WORD : `STEP_BYTE;
      `SZ_WORD: step = `STEP_WORD;
      default: step = `STEP_LONG;
    endcase
  end

  always_comb begin
    cur = is_addr ? areg[sel] : dreg[sel];
    ptr = areg[sel];
    if (LOCATE == 2'(opreg_pkg::SRC_EA) && eab.mode == `MODE_PREDEC)
      ptr = areg[sel] - step;
  end

  always_comb begin
    for (int i = 0; i < NUM_DREG; i++) next_dreg[i] = dreg[i];
    for (int i = 0; i < NUM_AREG; i++) next_areg[i] = areg[i];
    next_rd_data = RD_DATA;
    next_size_err = 1'b0;
    next_addr_hi = MEM_ADDR_HI;
    next_addr_lo = MEM_ADDR_LO;
    next_misaligned = 1'b0;
    // no byte operand on address registers
    if ((RD_EN || WR_EN) && is_addr && size == `SZ_BYTE &&
        !(LOCATE == 2'(opreg_pkg::SRC_EA) && eab.mode >= `MODE_IND))
      next_size_err = 1'b1;
    else begin
      if (RD_EN) begin
        // low portion zero extended by size
        case (size)
          `SZ_BYTE: next_rd_data = {24'h00_0000, cur[`BYTE_MSB:0]};
          `SZ_WORD: next_rd_data = {16'h0000, cur[`WORD_MSB:0]};
          default: next_rd_data = cur;
        endcase
      end
      if (WR_EN && is_addr) begin
        if (size == `SZ_WORD)
          next_areg[sel] = {{16{WR_DATA[`WORD_MSB]}}, WR_DATA[`WORD_MSB:0]};
        else
          next_areg[sel] = WR_DATA;
      end else if (WR_EN) begin
        // for byte and word only low portion of data register changes; long writes all of it
        case (size)
          `SZ_BYTE: next_dreg[sel][`BYTE_MSB:0] = WR_DATA[`BYTE_MSB:0];
          `SZ_WORD: next_dreg[sel][`WORD_MSB:0] = WR_DATA[`WORD_MSB:0];
          default: next_dreg[sel] = WR_DATA;
        endcase
      end
    end
    if (EA_ADJUST && LOCATE == 2'(opreg_pkg::SRC_EA)) begin
      // word address names the high byte
      next_addr_hi = ptr[23:0];
      // second word at n plus 2; low byte at n plus 1
      next_addr_lo = (size == `SZ_LONG) ? ptr[23:0] + `SECOND_WORD_OFS
                                         : ptr[23:0] + `LOW_BYTE_OFS;
      next_misaligned = (size != `SZ_BYTE) && ptr[0];
      if (eab.mode == `MODE_POSTINC)
        next_areg[sel] = areg[sel] + step;
      else if (eab.mode == `MODE_PREDEC)
        next_areg[sel] = ptr;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_DREG; i++) dreg[i] <= 32'h0000_0000;
      for (int i = 0; i < NUM_AREG; i++) areg[i] <= 32'h0000_0000;
      RD_DATA <= 32'h0000_0000;
      MEM_ADDR_HI <= 24'h00_0000;
      MEM_ADDR_LO <= 24'h00_0000;
      MISALIGNED <= 1'b0;
      SIZE_ERR <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_DREG; i++) dreg[i] <= next_dreg[i];
      for (int i = 0; i < NUM_AREG; i++) areg[i] <= next_areg[i];
      RD_DATA <= next_rd_data;
      MEM_ADDR_HI <= next_addr_hi;
      MEM_ADDR_LO <= next_addr_lo;
      MISALIGNED <= next_misaligned;
      SIZE_ERR <= next_size_err;
    end
  end

  property p_byte_read;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (RD_EN && !WR_EN && !is_addr && size == `SZ_BYTE)
      |=> RD_DATA[`LONG_MSB:`BYTE_MSB+1] == 24'h00_0000;
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("byte read high");

  property p_upper_kept;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (WR_EN && !is_addr && size == `SZ_WORD && !EA_ADJUST)
      |=> dreg[$past(sel)][`LONG_MSB:`WORD_MSB+1] ==
          $past(dreg[sel][`LONG_MSB:`WORD_MSB+1]);
  endproperty
  a_upper_kept: assert property (p_upper_kept)
    else $error("upper changed");

  property p_sext;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (WR_EN && is_addr && size == `SZ_WORD && !EA_ADJUST)
      |=> areg[$past(sel)] ==
          {{16{$past(WR_DATA[`WORD_MSB])}}, $past(WR_DATA[`WORD_MSB:0])};
  endproperty
  a_sext: assert property (p_sext)
    else $error("no sign extend");

  property p_no_abyte;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (WR_EN && is_addr && size == `SZ_BYTE &&
     LOCATE != 2'(opreg_pkg::SRC_EA))
      |=> SIZE_ERR;
  endproperty
  a_no_abyte: assert property (p_no_abyte)
    else $error("byte on areg");

  property p_long_pair;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (EA_ADJUST && LOCATE == 2'(opreg_pkg::SRC_EA) && size == `SZ_LONG)
      |=> MEM_ADDR_LO == MEM_ADDR_HI + `SECOND_WORD_OFS;
  endproperty
  a_long_pair: assert property (p_long_pair)
    else $error("long pair");

  property p_odd;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (EA_ADJUST && LOCATE == 2'(opreg_pkg::SRC_EA) &&
     size != `SZ_BYTE && ptr[0])
      |=> MISALIGNED;
  endproperty
  a_odd: assert property (p_odd)
    else $error("odd not flagged");

  sequence s_sp_post;
    EA_ADJUST && LOCATE == 2'(opreg_pkg::SRC_EA) &&
      eab.mode == `MODE_POSTINC &&
      sel == `SP_INDEX && size == `SZ_BYTE && !WR_EN;
  endsequence
  property p_sp_step;
    @(posedge CLK_SYS) disable iff (!RST_B)
    s_sp_post |=> areg[`SP_INDEX] == $past(areg[`SP_INDEX]) + `STEP_WORD;
  endproperty
  a_sp_step: assert property (p_sp_step)
    else $error("sp step");

  property p_fields;
    @(posedge CLK_SYS) disable iff (!RST_B)
    eab.mode == EA_FIELD[`EA_MODE_HI:`EA_MODE_LO] &&
      eab.regnum == EA_FIELD[`EA_REG_HI:`EA_REG_LO];
  endproperty
  a_fields: assert property (p_fields)
    else $error("ea fields");
endmodule

/* File: opreg_map.svh */
`ifndef OPREG_MAP_SVH
`define OPREG_MAP_SVH
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define BYTE_MSB 7
`define WORD_MSB 15
`define LONG_MSB 31
`define SP_INDEX 3'h7
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004
`define SECOND_WORD_OFS 24'h00_0002
`define LOW_BYTE_OFS 24'h00_0001
`define EA_MODE_HI 5
`define EA_MODE_LO 3
`define EA_REG_HI 2
`define EA_REG_LO 0
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`endif

/* File: opreg_mem_model.sv */
`timescale 1ns/10ps
module opreg_mem_model (
  input wire logic CLK_SYS,
  input wire logic STORE,
  input wire logic [23:0] ADDR_HI,
  input wire logic [23:0] ADDR_LO,
  input wire logic [31:0] DATA
);
  logic [7:0] mem [0:15];
  always_ff @(posedge CLK_SYS) begin
    if (STORE) begin
      mem[ADDR_HI[3:0]] <= DATA[31:24];
      mem[ADDR_HI[3:0] + 4'h1] <= DATA[23:16];
      mem[ADDR_LO[3:0]] <= DATA[15:8];
      mem[ADDR_LO[3:0] + 4'h1] <= DATA[7:0];
    end
  end
endmodule

/* File: opreg_pkg.sv */
package opreg_pkg;
  typedef enum logic [1:0] {
    SRC_FIELD,
    SRC_EA,
    SRC_IMPLIED
  } locate_e;
  typedef logic [1:0] size_t;
endpackage
